// ---- design/wpd_detector.sv ----
`timescale 1ns/1ps
// Function
// RULE_01: Scan only while control bit 7 set.
// RULE_02: Examine only own, multicast, broadcast frames.
// RULE_03: Require well-formed frame with good CRC.
// RULE_04: Station address repeated sixteen times, contiguous.
// RULE_05: Repetitions directly follow six FFh bytes.
// RULE_06: Pattern may start at any byte.
// RULE_07: Broadcast frames count when address matches.
// RULE_08: No other content condition applies.
// RULE_09: Missing pattern leaves alert untouched.
// RULE_10: Detection asserts the power wake alert.
// RULE_11: A breaking byte may restart a sync run.
module wpd_detector
	import wpd_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	input wire logic [7:0] WAKEUP_FRAME_CONTROL_REG_I,
	input wire logic [47:0] STATION_ADDR_I,
	input wire logic FRAME_START_I,
	input wire logic BYTE_VALID_I,
	input wire logic [7:0] BYTE_DATA_I,
	input wire logic FRAME_END_I,
	input wire logic CRC_OK_I,
	input wire logic FRAME_WELL_FORMED_I,
	input wire logic ALERT_CLEAR_I,
	output logic POWER_WAKE_ALERT_N_O,
	output logic WAKE_PATTERN_FRAME_O
);

	wpd_state_t state;
	wpd_state_t next_state;
	logic [2:0] sync_cnt;
	logic [2:0] next_sync_cnt;
	logic [2:0] byte_idx;
	logic [2:0] next_byte_idx;
	logic [4:0] rep_cnt;
	logic [4:0] next_rep_cnt;
	logic [2:0] da_idx;
	logic da_own;
	logic da_bcast;
	logic da_mcast;
	logic in_frame;
	logic alert_n;
	logic pattern_frame;
	logic clear_sync;

	// The clear request comes from the power-management domain, so it is
	// synchronised; the frame path is on our own clock and is used directly.
	wpd_sync3 u_clear_sync (
		.clk_i(CORE_CLK_I),
		.resetn_i(RESETN_I),
		.d_i(ALERT_CLEAR_I),
		.init_i(1'b0),
		.q_o(clear_sync)
	);

	wire scan_en = WAKEUP_FRAME_CONTROL_REG_I[WPD_ENABLE_BIT]; // [RULE_01]
	wire [2:0] addr_sel = 3'(WPD_ADDR_BYTES - 1) - byte_idx;
	wire [7:0] addr_byte = STATION_ADDR_I[{addr_sel, 3'b000} +: 8];
	wire [2:0] da_sel = 3'(WPD_ADDR_BYTES - 1) - da_idx;
	wire [7:0] da_own_byte = STATION_ADDR_I[{da_sel, 3'b000} +: 8];
	wire is_sync = BYTE_DATA_I == WPD_SYNC_VALUE;
	wire in_da = in_frame && (da_idx < 3'(WPD_ADDR_BYTES));
	wire addr_match = BYTE_DATA_I == addr_byte;
	wire last_addr_byte = byte_idx == 3'(WPD_ADDR_BYTES - 1);
	wire last_rep = rep_cnt == 5'(WPD_REPEATS - 1);
	wire scan_byte = scan_en && BYTE_VALID_I && in_frame && !FRAME_START_I;
	// A runt that never finished its destination field cannot qualify. [RULE_03]
	wire da_done = da_idx == 3'(WPD_ADDR_BYTES);
	// Own, multicast (group bit) or broadcast destination. [RULE_02] [RULE_07]
	wire dest_ok = da_done && (da_own || da_mcast || da_bcast);
	// Only sync, address match, well-formedness, CRC and destination are checked. [RULE_08]
	wire frame_good = FRAME_END_I && CRC_OK_I && FRAME_WELL_FORMED_I; // [RULE_03]
	wire hit = frame_good && dest_ok && (state == WPD_FOUND) && scan_en;

	// The pattern is hunted at every byte after the frame start. [RULE_06]
	always_comb
	begin
		next_state = state;
		next_sync_cnt = sync_cnt;
		next_byte_idx = byte_idx;
		next_rep_cnt = rep_cnt;
		if (FRAME_START_I || !scan_en)
		begin
			next_state = WPD_SYNC;
			next_sync_cnt = WPD_SYNC_CNT_RESET;
			next_byte_idx = WPD_BYTE_IDX_RESET;
			next_rep_cnt = WPD_REP_CNT_RESET;
		end
		else if (scan_byte)
		begin
			case (state)
				WPD_SYNC:
				begin
					// Six or more FFh bytes arm the address match. [RULE_05]
					if (is_sync && sync_cnt == 3'(WPD_SYNC_BYTES - 1))
						next_state = WPD_ADDR;
					else if (is_sync)
						next_sync_cnt = sync_cnt + 3'h1;
					else
						next_sync_cnt = WPD_SYNC_CNT_RESET;
				end
				WPD_ADDR:
				begin
					if (addr_match) // [RULE_04]
					begin
						if (last_addr_byte)
						begin
							next_byte_idx = WPD_BYTE_IDX_RESET;
							next_rep_cnt = rep_cnt + 5'h01;
							if (last_rep)
								next_state = WPD_FOUND;
						end
						else
							next_byte_idx = byte_idx + 3'h1;
					end
					else if (is_sync && byte_idx == WPD_BYTE_IDX_RESET
						&& rep_cnt == WPD_REP_CNT_RESET)
					begin
						// A seventh FFh just extends the sync run.
						next_state = WPD_ADDR;
					end
					else
					begin
						// The breaking byte may itself open a new sync run. [RULE_11]
						next_state = WPD_SYNC;
						next_byte_idx = WPD_BYTE_IDX_RESET;
						next_rep_cnt = WPD_REP_CNT_RESET;
						next_sync_cnt = is_sync ? 3'h1 : WPD_SYNC_CNT_RESET;
					end
				end
				WPD_FOUND:
				begin
					// The rest of the frame is ignored; only its CRC and well-formedness still decide.
					next_state = WPD_FOUND;
				end
				default:
					next_state = WPD_SYNC;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			state <= WPD_SYNC;
			sync_cnt <= WPD_SYNC_CNT_RESET;
			byte_idx <= WPD_BYTE_IDX_RESET;
			rep_cnt <= WPD_REP_CNT_RESET;
		end
		else
		begin
			state <= next_state;
			sync_cnt <= next_sync_cnt;
			byte_idx <= next_byte_idx;
			rep_cnt <= next_rep_cnt;
		end
	end

	// Destination check runs over the first six bytes of each frame.
	// The verdict is frozen after that, so later pattern bytes cannot alter it.
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			in_frame <= 1'b0;
			da_idx <= WPD_BYTE_IDX_RESET;
			da_own <= 1'b0;
			da_bcast <= 1'b0;
			da_mcast <= 1'b0;
		end
		else if (FRAME_START_I)
		begin
			in_frame <= 1'b1;
			da_idx <= WPD_BYTE_IDX_RESET;
			da_own <= 1'b1;
			da_bcast <= 1'b1;
			da_mcast <= 1'b0;
		end
		else if (FRAME_END_I)
			in_frame <= 1'b0;
		else if (BYTE_VALID_I && in_da)
		begin
			da_idx <= da_idx + 3'h1;
			da_own <= da_own && (BYTE_DATA_I == da_own_byte);
			da_bcast <= da_bcast && is_sync;
			if (da_idx == WPD_BYTE_IDX_RESET)
				da_mcast <= BYTE_DATA_I[0];
		end
	end

	// The pulse marks every wake frame, even while the alert is already low.
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			pattern_frame <= 1'b0;
		else
			pattern_frame <= hit; // [RULE_10]
	end

	// The alert holds until power management clears it; a detection in the
	// clearing cycle wins that cycle, but a clear still active the next cycle clears it again.
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			alert_n <= 1'b1;
		end
		else
		begin
			if (hit)
				alert_n <= 1'b0; // [RULE_10]
			else if (clear_sync)
				alert_n <= 1'b1;
			// A frame ending without the pattern leaves the alert alone. [RULE_09]
		end
	end

	assign POWER_WAKE_ALERT_N_O = alert_n;
	assign WAKE_PATTERN_FRAME_O = pattern_frame;

endmodule : wpd_detector

// ---- design/wpd_pkg.sv ----
package wpd_pkg;

	localparam int WPD_ADDR_BYTES = 6;
	localparam int WPD_SYNC_BYTES = 6;
	localparam int WPD_REPEATS = 16;
	localparam logic [7:0] WPD_SYNC_VALUE = 8'hFF;
	localparam int WPD_ENABLE_BIT = 7;
	localparam logic [7:0] WPD_CTRL_RESET = 8'h00;
	localparam logic [2:0] WPD_SYNC_CNT_RESET = 3'h0;
	localparam logic [2:0] WPD_BYTE_IDX_RESET = 3'h0;
	localparam logic [4:0] WPD_REP_CNT_RESET = 5'h00;

	typedef enum logic [1:0] {
		WPD_SYNC = 2'b00,
		WPD_ADDR = 2'b01,
		WPD_FOUND = 2'b10
	} wpd_state_t;

endpackage : wpd_pkg

// ---- design/wpd_sync3.sv ----
`timescale 1ns/1ps
// Three-stage synchroniser; a change is taken once stages two and three agree.
module wpd_sync3
	import wpd_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic d_i,
	input wire logic init_i,
	output logic q_o
);

	logic s1;
	logic s2;
	logic s3;
	logic q;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			q <= 1'b0;
		end
		else
		begin
			s1 <= d_i ^ init_i;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				q <= s3;
		end
	end

	assign q_o = q ^ init_i;

endmodule : wpd_sync3

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	localparam logic [47:0] STA = 48'h0A1B2C3D4E5F;
	logic clk = 1'b0, rstn = 1'b0, fs = 1'b0, bv = 1'b0, fe = 1'b0, ok = 1'b0, req = 1'b0;
	logic [7:0] ctl = 8'h80, bd = 8'h00;
	logic clr, alert_n, hit;
	int n_fail = 0, compares = 0;
	wpd_detector uut(.CORE_CLK_I(clk), .RESETN_I(rstn), .WAKEUP_FRAME_CONTROL_REG_I(ctl),
		.STATION_ADDR_I(STA), .FRAME_START_I(fs), .BYTE_VALID_I(bv), .BYTE_DATA_I(bd),
		.FRAME_END_I(fe), .CRC_OK_I(ok), .FRAME_WELL_FORMED_I(ok), .ALERT_CLEAR_I(clr),
		.POWER_WAKE_ALERT_N_O(alert_n), .WAKE_PATTERN_FRAME_O(hit));
	wpd_pm pm(.clk_i(clk), .req_i(req), .clr_o(clr));
	initial forever #25 clk = ~clk;
	task chk(input string nm, input logic e, input logic s);
		compares++;
		if (s !== e)
		begin
			n_fail++;
			$display("unexpected %s: expected %b seen %b", nm, e, s);
		end
	endtask : chk
	task put(input logic [7:0] b);
		bv = 1'b1;
		bd = b;
		@(negedge clk);
	endtask : put
	// A break run puts a partial address after six sync bytes, then a fresh sync starts.
	task frame(input logic [47:0] da, input int reps, input logic good, input logic brk, input logic e);
		fs = 1'b1;
		@(negedge clk);
		fs = 1'b0;
		for (int i = 0; i < 14; i++) put(i < 6 ? da[47 - 8 * i -: 8] : 8'h5A);
		for (int i = 0; i < (brk ? 8 : 0); i++) put(i < 6 ? 8'hFF : STA[47 - 8 * (i % 6) -: 8]);
		for (int i = 0; i < 6 + 6 * reps; i++) put(i < 6 ? 8'hFF : STA[47 - 8 * (i % 6) -: 8]);
		put(8'h00);
		bv = 1'b0;
		fe = 1'b1;
		ok = good;
		@(negedge clk);
		fe = 1'b0;
		chk("pulse", e, hit);
		chk("alert", !e, alert_n);
		req = e;
		@(negedge clk);
		req = 1'b0;
		repeat (8) @(negedge clk);
		chk("alert", 1'b1, alert_n);
	endtask : frame
	task t_bc;
		frame({6{8'hFF}}, 16, 1'b1, 1'b0, 1'b1);
	endtask : t_bc
	task t_brk;
		frame(STA, 16, 1'b1, 1'b1, 1'b1);
	endtask : t_brk
	task t_short;
		frame(STA, 15, 1'b1, 1'b0, 1'b0);
	endtask : t_short
	task t_mc;
		frame(48'h010000000002, 16, 1'b1, 1'b0, 1'b1);
	endtask : t_mc
	task t_crc;
		frame(STA, 16, 1'b0, 1'b0, 1'b0);
	endtask : t_crc
	task t_other;
		frame(48'h020000000001, 16, 1'b1, 1'b0, 1'b0);
	endtask : t_other
	task t_off;
		ctl = 8'h7F;
		frame(STA, 16, 1'b1, 1'b0, 1'b0);
		ctl = 8'h80;
	endtask : t_off
	task end_of_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	initial
	begin
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		t_bc;
		t_brk;
		t_short;
		t_mc;
		t_crc;
		t_other;
		t_off;
		end_of_test;
	end
endmodule : testbench
bind wpd_detector wpd_chk u_chk(.CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I),
	.WAKEUP_FRAME_CONTROL_REG_I(WAKEUP_FRAME_CONTROL_REG_I), .FRAME_END_I(FRAME_END_I),
	.CRC_OK_I(CRC_OK_I), .FRAME_WELL_FORMED_I(FRAME_WELL_FORMED_I),
	.ALERT_CLEAR_I(ALERT_CLEAR_I), .POWER_WAKE_ALERT_N_O(POWER_WAKE_ALERT_N_O),
	.WAKE_PATTERN_FRAME_O(WAKE_PATTERN_FRAME_O));

// ---- test/wpd_chk.sv ----
`timescale 1ns/1ps
module wpd_chk(
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	input wire logic [7:0] WAKEUP_FRAME_CONTROL_REG_I,
	input wire logic FRAME_END_I,
	input wire logic CRC_OK_I,
	input wire logic FRAME_WELL_FORMED_I,
	input wire logic ALERT_CLEAR_I,
	input wire logic POWER_WAKE_ALERT_N_O,
	input wire logic WAKE_PATTERN_FRAME_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESETN_I);
	AST_ONE: assert property (WAKE_PATTERN_FRAME_O |=> !WAKE_PATTERN_FRAME_O)
		else $error("hit too long");
	AST_END: assert property (WAKE_PATTERN_FRAME_O |-> $past(FRAME_END_I))
		else $error("hit off frame end");
	AST_EN: assert property (WAKE_PATTERN_FRAME_O |-> $past(WAKEUP_FRAME_CONTROL_REG_I[7]))
		else $error("hit while off");
	AST_OK: assert property (WAKE_PATTERN_FRAME_O |-> $past(CRC_OK_I && FRAME_WELL_FORMED_I))
		else $error("hit on bad frame");
	AST_SET: assert property (WAKE_PATTERN_FRAME_O |-> !POWER_WAKE_ALERT_N_O)
		else $error("alert not set");
	AST_FALL: assert property ($fell(POWER_WAKE_ALERT_N_O) |-> WAKE_PATTERN_FRAME_O)
		else $error("alert without hit");
	AST_RISE: assert property ($rose(POWER_WAKE_ALERT_N_O) |-> $past(ALERT_CLEAR_I, 2) || $past(ALERT_CLEAR_I, 4))
		else $error("alert lost");
	AST_STAY: assert property ((!ALERT_CLEAR_I [*6]) ##0 !POWER_WAKE_ALERT_N_O |=> !POWER_WAKE_ALERT_N_O)
		else $error("alert dropped");
	AST_CLR: assert property ($rose(ALERT_CLEAR_I) && !POWER_WAKE_ALERT_N_O |-> ##[1:6] POWER_WAKE_ALERT_N_O)
		else $error("clear ignored");
endmodule : wpd_chk

// ---- test/wpd_pm.sv ----
`timescale 1ns/1ps
// Power management stand-in: on request it holds the clear for five cycles, above the minimum.
module wpd_pm(
	input wire logic clk_i,
	input wire logic req_i,
	output logic clr_o
);
	logic [2:0] cnt = 3'h0;
	assign clr_o = cnt != 3'h0;
	always_ff @(posedge clk_i)
		cnt <= req_i ? 3'h5 : cnt - {2'h0, clr_o};
endmodule : wpd_pm
